// file: vc_tx_pkg.sv
// Constants and carrier types for the virtual channel transmit flow control
package vc_tx_pkg;
    localparam int NUM_CH_DEF    = 4;
    localparam int BUF_DEPTH_DEF = 512;
    localparam int FRAME_MAX     = 256;
    localparam int TOKEN_CREDIT  = 256;
    localparam int CREDIT_W      = 16;
    localparam int PRIO_W        = 4;
    localparam int CH_W          = 8;
    localparam int SEG_W         = 9;

    typedef enum logic [1:0] {
        QOS_ROUND_ROBIN,
        QOS_PRIORITY,
        QOS_RESERVED,
        QOS_SCHEDULED
    } qos_t;

    typedef struct packed {
        logic       eop;
        logic [7:0] data;
    } nchar_t;

    typedef struct packed {
        logic [CH_W-1:0] ch;
        logic            sof;
        logic            eof;
        nchar_t          c;
    } frame_word_t;
endpackage : vc_tx_pkg

// file: virtual_channel_tx_flow_control.sv
// Virtual channel transmit side: channel buffers, credit, arbitration, tokens
// Function
// [R1] Output buffer holds two full frames
// [R2] Concurrent per-channel writes, chunked packets allowed
// [R3] Ready when full frame or an end marker
// [R4] Nominate only when ready and credit available
// [R5] Per-channel quality-of-service picks the winner
// [R6] One channel at a time, frames interleaved
// [R7] Each token adds 256 characters of credit
// [R8] Credit is tokens times 256 minus sent
// [R9] Credit of 256 means one frame fits
// [R10] Emit token when input space frees a frame
// [R11] Tokens handed onward to framing
// [R12] Both ends together prevent input buffer overflow
// [R13] Frames carry at most 256 characters
// [R14] Token carries its channel number
// [R15] Reset or re-init clears credit
`timescale 1ns/1ps
module virtual_channel_tx_flow_control
    import vc_tx_pkg::*;
#(
    parameter int NUM_CH    = NUM_CH_DEF,
    parameter int BUF_DEPTH = BUF_DEPTH_DEF
) (
    input  wire  logic                           clock_in,
    input  wire  logic                           rst_n_in,
    input  wire  logic                           link_reinit_in,
    input  wire  logic [NUM_CH-1:0]              app_valid_in,
    input  wire  nchar_t [NUM_CH-1:0]            app_char_in,
    output logic [NUM_CH-1:0]                    app_ready_out,
    input  wire  qos_t [NUM_CH-1:0]              qos_mode_in,
    input  wire  logic [NUM_CH-1:0][PRIO_W-1:0]  qos_prio_in,
    input  wire  logic [CH_W-1:0]                sched_slot_in,
    input  wire  logic                           token_rx_valid_in,
    input  wire  logic [CH_W-1:0]                token_rx_ch_in,
    input  wire  logic [NUM_CH-1:0][CREDIT_W-1:0] in_free_in,
    input  wire  logic [NUM_CH-1:0]              in_char_rx_in,
    output logic                                 frame_valid_out,
    output frame_word_t                          frame_word_out,
    input  wire  logic                           frame_ready_in,
    output logic                                 token_valid_out,
    output logic [CH_W-1:0]                      token_ch_out,
    input  wire  logic                           token_ready_in,
    output logic [NUM_CH-1:0]                    nominated_out
);
    localparam int PW = $clog2(BUF_DEPTH);
    localparam int CW = $clog2(BUF_DEPTH + 1);
    localparam int IW = $clog2(NUM_CH);
    localparam logic [CW-1:0] DEPTH_C = CW'(BUF_DEPTH);
    localparam logic [CREDIT_W-1:0] TOKEN_C = CREDIT_W'(TOKEN_CREDIT);
    localparam logic [SEG_W-1:0] SEG_LAST = SEG_W'(FRAME_MAX - 1);
    localparam logic [CW-1:0] FRAME_C = CW'(FRAME_MAX);

    // Credit-style counter step, never wrapping below zero
    function automatic logic [CREDIT_W-1:0] step(
        input logic [CREDIT_W-1:0] val,
        input logic                add,
        input logic                sub);
        logic [CREDIT_W-1:0] tmp;
        tmp = add ? val + TOKEN_C : val;
        if (sub && tmp != '0) begin
            tmp = tmp - CREDIT_W'(1);
        end
        return tmp;
    endfunction : step

    // Ranking: scheduled slot owner, then reserved, priority, round robin
    function automatic logic [PRIO_W+1:0] rank(
        input qos_t              mode,
        input logic [PRIO_W-1:0] prio);
        logic [PRIO_W+1:0] r;
        case (mode)
            QOS_SCHEDULED: r = {2'h3, prio};
            QOS_RESERVED:  r = {2'h2, prio};
            QOS_PRIORITY:  r = {2'h1, prio};
            default:       r = '0;
        endcase
        return r;
    endfunction : rank

    nchar_t mem [NUM_CH][BUF_DEPTH];

    logic [NUM_CH-1:0][PW-1:0]       wr_ptr, next_wr_ptr;
    logic [NUM_CH-1:0][PW-1:0]       rd_ptr, next_rd_ptr;
    logic [NUM_CH-1:0][CW-1:0]       cnt, next_cnt;
    logic [NUM_CH-1:0][CW-1:0]       eops, next_eops;
    logic [NUM_CH-1:0][CREDIT_W-1:0] credit, next_credit;
    logic [NUM_CH-1:0][CREDIT_W-1:0] granted, next_granted;
    logic [NUM_CH-1:0]               next_app_ready, next_nominated;
    logic [NUM_CH-1:0]               wr_en, rd_en, buf_rdy, nom;
    logic                            active, next_active;
    logic [IW-1:0]                   cur_ch, next_cur_ch;
    logic [IW-1:0]                   rr_ptr, next_rr_ptr;
    logic [IW-1:0]                   scan_ch, next_scan_ch;
    logic [SEG_W-1:0]                seg, next_seg;
    logic                            v0, v1, next_v0, next_v1;
    frame_word_t                     d1, next_d0, next_d1;
    logic                            next_tok_valid;
    logic [CH_W-1:0]                 next_tok_ch;
    logic                            push, pop, found, tok_free, emit;
    frame_word_t                     push_word;
    nchar_t                          head;
    logic [PRIO_W+1:0]               best;
    logic [IW-1:0]                   pick;

    assign head = mem[cur_ch][rd_ptr[cur_ch]];

    // Channel buffers, credit and arbitration
    always_comb begin
        int idx;
        logic [PRIO_W+1:0] sc;
        idx = 0;
        sc = '0;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_cnt = cnt;
        next_eops = eops;
        next_credit = credit;
        next_active = active;
        next_cur_ch = cur_ch;
        next_rr_ptr = rr_ptr;
        next_seg = seg;
        push = 1'b0;
        push_word = '0;
        found = 1'b0;
        best = '0;
        pick = '0;
        for (int c = 0; c < NUM_CH; c++) begin
            wr_en[c] = app_valid_in[c] & app_ready_out[c]; // [R2]
            rd_en[c] = active && cur_ch == IW'(c) && cnt[c] != '0
                       && !v1; // [R6]
            buf_rdy[c] = cnt[c] >= FRAME_C || eops[c] != '0; // [R3]
            nom[c] = buf_rdy[c] && credit[c] >= TOKEN_C // [R4] [R9]
                     && (qos_mode_in[c] != QOS_SCHEDULED
                         || sched_slot_in == CH_W'(c));
        end
        // Ties keep rotating order so equal ranks share the link fairly
        if (!active) begin
            for (int i = 0; i < NUM_CH; i++) begin
                idx = int'(rr_ptr) + i;
                if (idx >= NUM_CH) begin
                    idx = idx - NUM_CH;
                end
                sc = rank(qos_mode_in[idx], qos_prio_in[idx]);
                if (nom[idx] && (!found || sc > best)) begin // [R5]
                    found = 1'b1;
                    best = sc;
                    pick = IW'(idx);
                end
            end
            if (found) begin
                next_active = 1'b1; // [R6]
                next_cur_ch = pick;
                next_seg = '0;
                next_rr_ptr = pick + IW'(1);
            end
        end
        if (|rd_en) begin
            push = 1'b1;
            push_word.ch = CH_W'(cur_ch); // [R14]
            push_word.sof = seg == '0;
            push_word.eof = head.eop || seg == SEG_LAST; // [R13]
            push_word.c = head;
            next_seg = seg + SEG_W'(1);
            if (push_word.eof) begin
                next_active = 1'b0; // [R6]
            end
        end
        for (int c = 0; c < NUM_CH; c++) begin
            if (wr_en[c]) begin
                next_wr_ptr[c] = wr_ptr[c] + PW'(1);
            end
            if (rd_en[c]) begin
                next_rd_ptr[c] = rd_ptr[c] + PW'(1);
            end
            next_cnt[c] = cnt[c] + CW'(wr_en[c]) - CW'(rd_en[c]);
            next_eops[c] = eops[c]
                           + CW'(wr_en[c] & app_char_in[c].eop)
                           - CW'(rd_en[c] & head.eop);
            next_credit[c] = step(credit[c],
                                  token_rx_valid_in
                                  && token_rx_ch_in == CH_W'(c),
                                  rd_en[c]); // [R7] [R8]
            if (link_reinit_in) begin
                next_credit[c] = '0; // [R15]
            end
            next_app_ready[c] = next_cnt[c] < DEPTH_C; // [R1]
            next_nominated[c] = nom[c];
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            cnt <= '0;
            eops <= '0;
            credit <= '0; // [R15]
            app_ready_out <= '0;
            nominated_out <= '0;
            active <= 1'b0;
            cur_ch <= '0;
            rr_ptr <= '0;
            seg <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            cnt <= next_cnt;
            eops <= next_eops;
            credit <= next_credit;
            app_ready_out <= next_app_ready;
            nominated_out <= next_nominated;
            active <= next_active;
            cur_ch <= next_cur_ch;
            rr_ptr <= next_rr_ptr;
            seg <= next_seg;
        end
    end

    // Storage has no reset; pointers and counts decide what is valid
    always_ff @(posedge clock_in) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (wr_en[c]) begin
                mem[c][wr_ptr[c]] <= app_char_in[c];
            end
        end
    end

    // Two-entry output buffer; a stalled receiver holds words, none lost
    always_comb begin
        pop = v0 & frame_ready_in;
        next_v0 = v0;
        next_v1 = v1;
        next_d0 = frame_word_out;
        next_d1 = d1;
        if (pop) begin
            next_d0 = d1;
            next_v0 = v1;
            next_v1 = 1'b0;
        end
        if (push) begin
            if (!next_v0) begin
                next_d0 = push_word;
                next_v0 = 1'b1;
            end else begin
                next_d1 = push_word;
                next_v1 = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            v0 <= 1'b0;
            v1 <= 1'b0;
            frame_valid_out <= 1'b0;
            frame_word_out <= '0;
            d1 <= '0;
        end else begin
            v0 <= next_v0;
            v1 <= next_v1;
            frame_valid_out <= next_v0;
            frame_word_out <= next_d0;
            d1 <= next_d1;
        end
    end

    // Token generator: one channel examined per cycle in rotation
    always_comb begin
        tok_free = !token_valid_out || token_ready_in;
        emit = tok_free
               && in_free_in[scan_ch] >= granted[scan_ch] + TOKEN_C; // [R10]
        next_tok_valid = token_valid_out && !token_ready_in;
        next_tok_ch = token_ch_out;
        if (emit) begin
            next_tok_valid = 1'b1; // [R11]
            next_tok_ch = CH_W'(scan_ch); // [R14]
        end
        next_scan_ch = (int'(scan_ch) == NUM_CH - 1) ? '0
                       : scan_ch + IW'(1);
        for (int c = 0; c < NUM_CH; c++) begin
            // Granted space stays reserved until the characters arrive
            next_granted[c] = step(granted[c],
                                   emit && scan_ch == IW'(c),
                                   in_char_rx_in[c]); // [R12]
            if (link_reinit_in) begin
                next_granted[c] = '0;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            token_valid_out <= 1'b0;
            token_ch_out <= '0;
            scan_ch <= '0;
            granted <= '0;
        end else begin
            token_valid_out <= next_tok_valid;
            token_ch_out <= next_tok_ch;
            scan_ch <= next_scan_ch;
            granted <= next_granted;
        end
    end
endmodule : virtual_channel_tx_flow_control

// file: vc_tx_assertions.sv
// Port checker for the virtual channel transmit side
`timescale 1ns/1ps
module vc_tx_assertions
    import vc_tx_pkg::*;
#(parameter int NUM_CH = NUM_CH_DEF) (
    input wire logic              clock_in,
    input wire logic              rst_n_in,
    input wire logic              link_reinit_in,
    input wire logic              token_rx_valid_in,
    input wire logic [CH_W-1:0]   token_rx_ch_in,
    input wire logic [NUM_CH-1:0] app_ready_out,
    input wire logic [NUM_CH-1:0] nominated_out,
    input wire logic              frame_valid_out,
    input wire frame_word_t       frame_word_out,
    input wire logic              frame_ready_in,
    input wire logic              token_valid_out,
    input wire logic [CH_W-1:0]   token_ch_out,
    input wire logic              token_ready_in
);
    logic              take;
    logic              in_frame;
    logic [CH_W-1:0]   cur_ch;
    logic [8:0]        wcnt;
    logic [NUM_CH-1:0] got;
    logic [2:0]        rq;
    assign take = frame_valid_out && frame_ready_in;
    // Nomination lags credit, so checks pause a few cycles after a clear
    always_ff @(posedge clock_in) begin
        rq <= {rq[1:0], link_reinit_in || !rst_n_in};
        if (!rst_n_in || link_reinit_in)
            got <= '0;
        else if (token_rx_valid_in && token_rx_ch_in < NUM_CH)
            got[token_rx_ch_in] <= 1'b1;
        if (!rst_n_in) begin
            in_frame <= 1'b0;
            wcnt <= 9'h0;
        end else if (take) begin
            in_frame <= !frame_word_out.eof;
            cur_ch <= frame_word_out.ch;
            wcnt <= frame_word_out.eof ? 9'h0 : wcnt + 9'h1;
        end
    end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    a_frame_word_hold: assert property (
        frame_valid_out && !frame_ready_in
        |=> frame_valid_out && $stable(frame_word_out))
        else $error("frame word changed before taken");
    a_token_hold: assert property (
        token_valid_out && !token_ready_in
        |=> token_valid_out && $stable(token_ch_out))
        else $error("token changed before taken");
    a_token_chan: assert property (
        token_valid_out |-> token_ch_out < NUM_CH)
        else $error("token channel out of range");
    a_reset_quiet: assert property (
        disable iff (1'b0) !rst_n_in |=> app_ready_out == '0
        && !frame_valid_out && !token_valid_out && nominated_out == '0)
        else $error("outputs active after reset");
    a_segment_len: assert property (
        take && wcnt == 9'hff |-> frame_word_out.eof)
        else $error("frame longer than 256");
    a_frame_start: assert property (
        take && !in_frame |-> frame_word_out.sof)
        else $error("frame without start");
    a_frame_chan: assert property (
        take && in_frame
        |-> !frame_word_out.sof && frame_word_out.ch == cur_ch)
        else $error("frames mixed inside one frame");
    a_eop_closes: assert property (
        take && frame_word_out.c.eop |-> frame_word_out.eof)
        else $error("end marker did not close frame");
    a_nom_credit: assert property (
        rq == 3'h0 |-> (nominated_out & ~got) == '0)
        else $error("nominated without credit");
    a_start_credit: assert property (
        take && frame_word_out.sof && rq == 3'h0 |-> got[frame_word_out.ch])
        else $error("frame sent without credit");
    c_frame_end: cover property (take && frame_word_out.eof);
    c_stall: cover property (frame_valid_out && !frame_ready_in);
    c_token: cover property (token_valid_out && token_ready_in);
    c_full: cover property (app_ready_out != '1);
endmodule : vc_tx_assertions
bind virtual_channel_tx_flow_control vc_tx_assertions #(.NUM_CH(NUM_CH))
    vc_tx_assertions_inst (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .link_reinit_in(link_reinit_in),
    .token_rx_valid_in(token_rx_valid_in),
    .token_rx_ch_in(token_rx_ch_in),
    .app_ready_out(app_ready_out),
    .nominated_out(nominated_out),
    .frame_valid_out(frame_valid_out),
    .frame_word_out(frame_word_out),
    .frame_ready_in(frame_ready_in),
    .token_valid_out(token_valid_out),
    .token_ch_out(token_ch_out),
    .token_ready_in(token_ready_in));

// file: vc_far_end.sv
// Far-side framing model: takes frame words and tokens, may stall
`timescale 1ns/1ps
module vc_far_end
    import vc_tx_pkg::*;
(
    input  wire logic            clock_in,
    input  wire logic            rst_n_in,
    input  wire logic            stall_in,
    input  wire logic            frame_valid_in,
    input  wire frame_word_t     frame_word_in,
    output logic                 frame_ready_out = 1'b0,
    input  wire logic            token_valid_in,
    input  wire logic [CH_W-1:0] token_ch_in,
    output logic                 token_ready_out = 1'b0
);
    frame_word_t     words[$];
    logic [CH_W-1:0] tokens[$];
    always @(posedge clock_in) begin
        if (!rst_n_in) begin
            frame_ready_out <= 1'b0;
            token_ready_out <= 1'b0;
        end else begin
            // Alternate stalls fill the two-entry buffer
            frame_ready_out <= !stall_in || !frame_ready_out;
            token_ready_out <= !token_ready_out;
            if (frame_valid_in && frame_ready_out)
                words.push_back(frame_word_in);
            if (token_valid_in && token_ready_out)
                tokens.push_back(token_ch_in);
        end
    end
endmodule : vc_far_end

// file: tb_virtual_channel_tx_flow_control.sv
// Self-checking bench for the virtual channel transmit side
`timescale 1ns/1ps
module tb_virtual_channel_tx_flow_control;
    import vc_tx_pkg::*;
    localparam int NC = 4;
    logic clock_in = 0, rst_n_in = 0, link_reinit_in = 0, stall = 0;
    logic token_rx_valid_in = 0, frame_valid_out, token_valid_out;
    logic frame_ready_in, token_ready_in;
    logic [NC-1:0] app_valid_in = '0, in_char_rx_in = '0;
    logic [NC-1:0] app_ready_out, nominated_out;
    nchar_t [NC-1:0] app_char_in = '0;
    qos_t [NC-1:0] qos_mode_in = '{default: QOS_ROUND_ROBIN};
    logic [NC-1:0][PRIO_W-1:0] qos_prio_in = '0;
    logic [CH_W-1:0] sched_slot_in = '0, token_rx_ch_in = '0, token_ch_out;
    logic [NC-1:0][CREDIT_W-1:0] in_free_in = '0;
    frame_word_t frame_word_out;
    int err_count = 0, n_tests = 0, cyc = 0;
    virtual_channel_tx_flow_control #(.NUM_CH(NC), .BUF_DEPTH(512))
        virtual_channel_tx_flow_control_inst (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .link_reinit_in(link_reinit_in),
        .app_valid_in(app_valid_in),
        .app_char_in(app_char_in),
        .app_ready_out(app_ready_out),
        .qos_mode_in(qos_mode_in),
        .qos_prio_in(qos_prio_in),
        .sched_slot_in(sched_slot_in),
        .token_rx_valid_in(token_rx_valid_in),
        .token_rx_ch_in(token_rx_ch_in),
        .in_free_in(in_free_in),
        .in_char_rx_in(in_char_rx_in),
        .frame_valid_out(frame_valid_out),
        .frame_word_out(frame_word_out),
        .frame_ready_in(frame_ready_in),
        .token_valid_out(token_valid_out),
        .token_ch_out(token_ch_out),
        .token_ready_in(token_ready_in),
        .nominated_out(nominated_out));
    vc_far_end vc_far_end_inst (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .stall_in(stall), .frame_valid_in(frame_valid_out),
        .frame_word_in(frame_word_out), .frame_ready_out(frame_ready_in),
        .token_valid_in(token_valid_out), .token_ch_in(token_ch_out),
        .token_ready_out(token_ready_in));
    always #5 clock_in = ~clock_in;
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            report_and_stop();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic put(input int ch, input int n, input logic eop);
        for (int i = 0; i < n; i++) begin
            app_valid_in[ch] <= 1'b1;
            app_char_in[ch] <= '{eop: eop && i == n - 1, data: 8'(i)};
            do @(posedge clock_in); while (!app_ready_out[ch]);
        end
        app_valid_in[ch] <= 1'b0;
    endtask : put
    task automatic token(input int ch, input int n);
        token_rx_valid_in <= 1'b1;
        token_rx_ch_in <= 8'(ch);
        repeat (n) @(posedge clock_in);
        token_rx_valid_in <= 1'b0;
        @(posedge clock_in);
    endtask : token
    task automatic wait_words(input int n);
        for (int i = 0; i < 3000 && vc_far_end_inst.words.size() < n; i++)
            @(posedge clock_in);
        check(vc_far_end_inst.words.size(), n);
    endtask : wait_words
    task automatic frame(input int at, input int ch, input int len, input int b);
        frame_word_t w;
        for (int k = 0; k < len; k++) begin
            w = vc_far_end_inst.words[at + k];
            check({w.ch, w.sof, w.eof, w.c.data},
                {8'(ch), k == 0, k == len - 1, 8'(b + k)});
        end
    endtask : frame
    task automatic t_eop_frame();
        put(0, 3, 1'b1);
        repeat (30) @(posedge clock_in);
        check(vc_far_end_inst.words.size(), 0);
        token(0, 1);
        // Status register shows the nomination two edges after the token
        @(posedge clock_in);
        check(nominated_out, 4'h1);
        wait_words(3);
        frame(0, 0, 3, 0);
    endtask : t_eop_frame
    task automatic t_fill_drain();
        stall <= 1'b1;
        vc_far_end_inst.words.delete();
        put(2, 512, 1'b0);
        repeat (3) @(posedge clock_in);
        check(app_ready_out[2], 1'b0);
        token(2, 2);
        wait_words(512);
        frame(0, 2, 256, 0);
        frame(256, 2, 256, 0);
        check(app_ready_out[2], 1'b1);
        put(2, 1, 1'b1);
        repeat (30) @(posedge clock_in);
        check(vc_far_end_inst.words.size(), 512);
        token(2, 1);
        wait_words(513);
        stall <= 1'b0;
    endtask : t_fill_drain
    task automatic t_qos();
        token(0, 3);
        token(3, 3);
        for (int m = 0; m < 4; m++) begin
            qos_mode_in[3] <= qos_t'(m);
            qos_prio_in[3] <= 4'hf;
            sched_slot_in <= 8'h3;
            vc_far_end_inst.words.delete();
            fork
                put(0, 2, 1'b1);
                put(3, 2, 1'b1);
            join
            wait_words(4);
            if (m > 0)
                check(vc_far_end_inst.words[0].ch, 8'h3);
            check(vc_far_end_inst.words[2].sof, 1'b1);
        end
    endtask : t_qos
    task automatic t_tokens();
        in_free_in[1] <= 16'h200;
        repeat (40) @(posedge clock_in);
        check(vc_far_end_inst.tokens.size(), 2);
        check(vc_far_end_inst.tokens[0], 8'h1);
        in_char_rx_in[1] <= 1'b1;
        repeat (256) @(posedge clock_in);
        in_char_rx_in[1] <= 1'b0;
        repeat (40) @(posedge clock_in);
        check(vc_far_end_inst.tokens.size(), 3);
        in_free_in[1] <= 16'h0;
    endtask : t_tokens
    task automatic t_reinit();
        vc_far_end_inst.words.delete();
        token(1, 1);
        link_reinit_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        link_reinit_in <= 1'b0;
        put(1, 2, 1'b1);
        repeat (40) @(posedge clock_in);
        check(vc_far_end_inst.words.size(), 0);
        check(nominated_out, 4'h0);
    endtask : t_reinit
    initial begin
        repeat (16) @(posedge clock_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        check(app_ready_out, 4'hf);
        t_eop_frame();
        t_fill_drain();
        t_qos();
        t_tokens();
        t_reinit();
        report_and_stop();
    end
endmodule : tb_virtual_channel_tx_flow_control
